/* File: rtl/ascp_pkg.sv */
// Summary of operation
// - Frame: start, seven data, even parity, stop
// - Bit rate 9600, 19200 or 38400 selectable
// - Factory default rate is 9600 bps
// - Full duplex or shared-pair half duplex
// - Transmit driver floats when not sending
package ascp_pkg;
	localparam int unsigned CLK_HZ        = 25000000; // System clock rate
	localparam int unsigned OVS           = 16;       // Receive samples per bit
	localparam int unsigned BAUD_9600     = 9600;     // Slowest rate
	localparam int unsigned BAUD_19200    = 19200;    // Middle rate
	localparam int unsigned BAUD_38400    = 38400;    // Fastest rate
	localparam int unsigned DATA_BITS     = 7;        // ASCII data width
	localparam int unsigned FRAME_BITS    = 10;       // Start, data, parity, stop
	localparam int unsigned DIV_W         = 10;       // Tick divider width
	localparam int unsigned SMP_MID       = 7;        // Sample index at bit centre
	// Divider reload per rate, rounded down
	localparam logic [9:0] DIV_9600  = 10'(CLK_HZ / (BAUD_9600 * OVS) - 1);
	localparam logic [9:0] DIV_19200 = 10'(CLK_HZ / (BAUD_19200 * OVS) - 1);
	localparam logic [9:0] DIV_38400 = 10'(CLK_HZ / (BAUD_38400 * OVS) - 1);

	// Bit-rate selector values
	typedef enum logic [1:0] {
		ASCP_RATE_9600  = 2'h0,
		ASCP_RATE_19200 = 2'h1,
		ASCP_RATE_38400 = 2'h2
	} ascp_rate_type;

	localparam ascp_rate_type RATE_DEFAULT = ASCP_RATE_9600; // Factory setting

	// Duplex selector values
	typedef enum logic {
		ASCP_FULL_DUPLEX = 1'b0,
		ASCP_HALF_DUPLEX = 1'b1
	} ascp_duplex_type;

	// Received character with status
	typedef struct packed {
		logic [6:0] data;
		logic       parity_err;
		logic       frame_err;
	} ascp_rx_char_type;

	// Line pin bundle toward the transceivers
	typedef struct packed {
		logic tx_out;
		logic tx_oe;
	} ascp_line_type;

	// Even parity over seven data bits
	function automatic logic ascp_parity(input logic [6:0] d);
		ascp_parity = ^d;
	endfunction : ascp_parity
endpackage : ascp_pkg

/* File: rtl/ascp_tick_gen.sv */
// Oversample tick generator at 16x the chosen bit rate
module ascp_tick_gen (
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   en_in,
	input  wire ascp_pkg::ascp_rate_type rate_in,
	output logic                        tick_out
);
	import ascp_pkg::*;

	// Module state
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} ascp_tick_state_type;

	ascp_tick_state_type st_r;  // Registered state
	ascp_tick_state_type st_nxt; // Next state
	logic [DIV_W-1:0]    reload; // Divider reload for rate

	// Select reload per rate
	always_comb begin
		unique case (rate_in)
			ASCP_RATE_19200: reload = DIV_19200;
			ASCP_RATE_38400: reload = DIV_38400;
			default:         reload = DIV_9600;  // Illegal codes fall back to 9600
		endcase
	end

	// Countdown and tick
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == '0) begin
			st_nxt.cnt  = reload;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else if (en_in) begin
			st_r <= st_nxt;
		end
	end

	assign tick_out = st_r.tick;
endmodule : ascp_tick_gen

/* File: rtl/ascp_serial_port.sv */
// Serial command port transceiver, 7E1 framing, floating transmitter
module ascp_serial_port (
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_n_in,
	input  wire logic                      clk_en_in,
	input  wire ascp_pkg::ascp_rate_type   bit_rate_select_param_in,
	input  wire ascp_pkg::ascp_duplex_type duplex_select_param_in,
	input  wire logic                      rxd_in,
	input  wire logic                      tx_valid_in,
	input  wire logic [6:0]                tx_data_in,
	output logic                           tx_ready_out,
	output logic                           txd_out,
	output logic                           txd_oe_out,
	output logic                           rx_valid_out,
	output ascp_pkg::ascp_rx_char_type     rx_char_out,
	output logic                           rx_err_out
);
	import ascp_pkg::*;

	// Transmit states, Gray along idle-start-data-parity-stop
	typedef enum logic [2:0] {
		TX_IDLE  = 3'h0,
		TX_START = 3'h1,
		TX_DATA  = 3'h3,
		TX_PAR   = 3'h2,
		TX_STOP  = 3'h6
	} ascp_tx_state_type;

	// Receive states, Gray along usual path
	typedef enum logic [2:0] {
		RX_IDLE  = 3'h0,
		RX_START = 3'h1,
		RX_DATA  = 3'h3,
		RX_PAR   = 3'h2,
		RX_STOP  = 3'h6
	} ascp_rx_state_type;

	// Whole module state
	typedef struct packed {
		logic [1:0]        rxd_sync;  // Receive pin synchroniser
		ascp_rate_type     rate;      // Latched rate
		ascp_duplex_type   duplex;    // Latched duplex mode
		ascp_tx_state_type tx_st;     // Transmit state
		logic [3:0]        tx_smp;    // Transmit tick count in bit
		logic [2:0]        tx_bit;    // Transmit data bit index
		logic [6:0]        tx_sh;     // Transmit shift register
		logic              tx_par;    // Transmit parity bit
		logic              txd;       // Line level
		logic              txd_oe;    // Driver enable
		logic              tx_ready;  // Ready for a character
		ascp_rx_state_type rx_st;     // Receive state
		logic [3:0]        rx_smp;    // Receive tick count in bit
		logic [2:0]        rx_bit;    // Receive data bit index
		logic [6:0]        rx_sh;     // Receive shift register
		logic              rx_par;    // Received parity bit
		logic              rx_valid;  // Character pulse
		ascp_rx_char_type  rx_char;   // Last character
		logic              rx_err;    // Error pulse
	} ascp_state_type;

	ascp_state_type st_r;   // Registered state
	ascp_state_type st_nxt; // Next state
	logic [1:0]     rst_sync_r; // Reset release stages, pin reset domain
	logic           rst_n;  // Synchronised reset
	logic           tick;   // Oversample tick
	logic           rxd_s;  // Synchronised, mode-gated receive level
	logic           last_smp_tx; // End of a transmit bit
	logic           last_smp_rx; // End of a receive bit

	// Reset release through two stages, kept out of the state word as it resets on the pin
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_r <= '0;
		end else if (clk_en_in) begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_r[1];

	// Bit-rate ticks
	ascp_tick_gen u_tick (
		.clk_in   (ref_clk_in),
		.rst_n_in (rst_n),
		.en_in    (clk_en_in),
		.rate_in  (st_r.rate),
		.tick_out (tick)
	);

	// In half duplex our own echo is ignored while driving
	assign rxd_s = (st_r.duplex == ASCP_HALF_DUPLEX && st_r.txd_oe) ? 1'b1 : st_r.rxd_sync[1];
	assign last_smp_tx = tick && (st_r.tx_smp == 4'(OVS - 1));
	assign last_smp_rx = tick && (st_r.rx_smp == 4'(OVS - 1));

	// Next-state logic for both directions
	always_comb begin
		st_nxt          = st_r;
		st_nxt.rxd_sync = {st_r.rxd_sync[0], rxd_in};
		st_nxt.rx_valid = 1'b0;
		st_nxt.rx_err   = 1'b0;
		// Parameters only change while both directions idle
		if (st_r.tx_st == TX_IDLE && st_r.rx_st == RX_IDLE) begin
			st_nxt.rate   = bit_rate_select_param_in;
			st_nxt.duplex = duplex_select_param_in;
		end
		if (tick) begin
			st_nxt.tx_smp = st_r.tx_smp + 1'b1;
		end
		// Transmitter
		unique case (st_r.tx_st)
			TX_IDLE: begin
				st_nxt.txd_oe   = 1'b0;
				st_nxt.txd      = 1'b1;
				st_nxt.tx_ready = 1'b1;
				if (tx_valid_in && st_r.tx_ready) begin
					st_nxt.tx_sh    = tx_data_in;
					st_nxt.tx_par   = ascp_parity(tx_data_in);
					st_nxt.tx_ready = 1'b0;
					st_nxt.tx_smp   = '0;
					st_nxt.tx_st    = TX_START;
					st_nxt.txd      = 1'b0;
					st_nxt.txd_oe   = 1'b1;
				end
			end
			TX_START: begin
				if (last_smp_tx) begin
					st_nxt.tx_st  = TX_DATA;
					st_nxt.tx_bit = '0;
					st_nxt.txd    = st_r.tx_sh[0];
				end
			end
			TX_DATA: begin
				if (last_smp_tx) begin
					if (st_r.tx_bit == 3'(DATA_BITS - 1)) begin
						st_nxt.tx_st = TX_PAR;
						st_nxt.txd   = st_r.tx_par;
					end else begin
						st_nxt.tx_bit = st_r.tx_bit + 1'b1;
						st_nxt.tx_sh  = {1'b0, st_r.tx_sh[6:1]};
						st_nxt.txd    = st_r.tx_sh[1];
					end
				end
			end
			TX_PAR: begin
				if (last_smp_tx) begin
					st_nxt.tx_st = TX_STOP;
					st_nxt.txd   = 1'b1;
				end
			end
			TX_STOP: begin
				if (last_smp_tx) begin
					st_nxt.tx_st  = TX_IDLE;
					st_nxt.txd_oe = 1'b0;
				end
			end
			default: begin
				st_nxt.tx_st  = TX_IDLE;
				st_nxt.txd_oe = 1'b0;
			end
		endcase
		// Receiver
		if (tick) begin
			st_nxt.rx_smp = st_r.rx_smp + 1'b1;
		end
		unique case (st_r.rx_st)
			RX_IDLE: begin
				if (!rxd_s) begin
					st_nxt.rx_st  = RX_START;
					st_nxt.rx_smp = '0;
				end
			end
			RX_START: begin
				if (tick && st_r.rx_smp == 4'(SMP_MID)) begin
					if (rxd_s) begin
						st_nxt.rx_st = RX_IDLE; // Glitch, not a start bit
					end
				end
				if (last_smp_rx) begin
					st_nxt.rx_st  = RX_DATA;
					st_nxt.rx_bit = '0;
				end
			end
			RX_DATA: begin
				if (tick && st_r.rx_smp == 4'(SMP_MID)) begin
					st_nxt.rx_sh = {rxd_s, st_r.rx_sh[6:1]};
				end
				if (last_smp_rx) begin
					if (st_r.rx_bit == 3'(DATA_BITS - 1)) begin
						st_nxt.rx_st = RX_PAR;
					end else begin
						st_nxt.rx_bit = st_r.rx_bit + 1'b1;
					end
				end
			end
			RX_PAR: begin
				if (tick && st_r.rx_smp == 4'(SMP_MID)) begin
					st_nxt.rx_par = rxd_s;
				end
				if (last_smp_rx) begin
					st_nxt.rx_st = RX_STOP;
				end
			end
			RX_STOP: begin
				// Finish at the stop-bit centre to catch back-to-back starts
				if (tick && st_r.rx_smp == 4'(SMP_MID)) begin
					st_nxt.rx_st              = RX_IDLE;
					st_nxt.rx_valid           = 1'b1;
					st_nxt.rx_char.data       = st_r.rx_sh;
					st_nxt.rx_char.parity_err = ascp_parity(st_r.rx_sh) != st_r.rx_par;
					st_nxt.rx_char.frame_err  = !rxd_s;
					st_nxt.rx_err = (ascp_parity(st_r.rx_sh) != st_r.rx_par) || !rxd_s;
				end
			end
			default: begin
				st_nxt.rx_st = RX_IDLE;
			end
		endcase
	end

	// State register, all but reset stages
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_r.rxd_sync <= 2'h3;
			st_r.rate     <= RATE_DEFAULT;
			st_r.duplex   <= ASCP_FULL_DUPLEX;
			st_r.tx_st    <= TX_IDLE;
			st_r.tx_smp   <= '0;
			st_r.tx_bit   <= '0;
			st_r.tx_sh    <= '0;
			st_r.tx_par   <= 1'b0;
			st_r.txd      <= 1'b1;
			st_r.txd_oe   <= 1'b0;
			st_r.tx_ready <= 1'b0;
			st_r.rx_st    <= RX_IDLE;
			st_r.rx_smp   <= '0;
			st_r.rx_bit   <= '0;
			st_r.rx_sh    <= '0;
			st_r.rx_par   <= 1'b0;
			st_r.rx_valid <= 1'b0;
			st_r.rx_char  <= '0;
			st_r.rx_err   <= 1'b0;
		end else if (clk_en_in) begin
			st_r.rxd_sync <= st_nxt.rxd_sync;
			st_r.rate     <= st_nxt.rate;
			st_r.duplex   <= st_nxt.duplex;
			st_r.tx_st    <= st_nxt.tx_st;
			st_r.tx_smp   <= st_nxt.tx_smp;
			st_r.tx_bit   <= st_nxt.tx_bit;
			st_r.tx_sh    <= st_nxt.tx_sh;
			st_r.tx_par   <= st_nxt.tx_par;
			st_r.txd      <= st_nxt.txd;
			st_r.txd_oe   <= st_nxt.txd_oe;
			st_r.tx_ready <= st_nxt.tx_ready;
			st_r.rx_st    <= st_nxt.rx_st;
			st_r.rx_smp   <= st_nxt.rx_smp;
			st_r.rx_bit   <= st_nxt.rx_bit;
			st_r.rx_sh    <= st_nxt.rx_sh;
			st_r.rx_par   <= st_nxt.rx_par;
			st_r.rx_valid <= st_nxt.rx_valid;
			st_r.rx_char  <= st_nxt.rx_char;
			st_r.rx_err   <= st_nxt.rx_err;
		end
	end

	// Outputs straight from flip-flops
	assign tx_ready_out = st_r.tx_ready;
	assign txd_out      = st_r.txd;
	assign txd_oe_out   = st_r.txd_oe;
	assign rx_valid_out = st_r.rx_valid;
	assign rx_char_out  = st_r.rx_char;
	assign rx_err_out   = st_r.rx_err;
endmodule : ascp_serial_port

/* File: verif/ascp_serial_port_chk.sv */
module ascp_serial_port_chk (
	input wire logic                      ref_clk_in,
	input wire logic                      rst_n_in,
	input wire logic                      clk_en_in,
	input wire ascp_pkg::ascp_rate_type   bit_rate_select_param_in,
	input wire ascp_pkg::ascp_duplex_type duplex_select_param_in,
	input wire logic                      rxd_in,
	input wire logic                      tx_valid_in,
	input wire logic [6:0]                tx_data_in,
	input wire logic                      tx_ready_out,
	input wire logic                      txd_out,
	input wire logic                      txd_oe_out,
	input wire logic                      rx_valid_out,
	input wire ascp_pkg::ascp_rx_char_type rx_char_out,
	input wire logic                      rx_err_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import ascp_pkg::*;
	// One domain, reset turns all checks off
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_tx_accept: assert property (tx_valid_in && tx_ready_out && clk_en_in |=> txd_oe_out && !txd_out && !tx_ready_out)
		else $error("accepted character did not start a frame");
	a_start_hold: assert property ($rose(txd_oe_out) |-> !txd_out [*8])
		else $error("start bit too short");
	a_stop_last: assert property ($fell(txd_oe_out) |-> $past(txd_out))
		else $error("driver released before stop level");
	a_idle_high: assert property (!txd_oe_out |-> txd_out)
		else $error("line level low while released");
	a_busy_float: assert property (txd_oe_out |-> !tx_ready_out)
		else $error("ready while driving a frame");
	a_err_valid: assert property (rx_err_out |-> rx_valid_out)
		else $error("error pulse without character");
	a_err_sum: assert property (rx_valid_out |-> rx_err_out == (rx_char_out.parity_err || rx_char_out.frame_err))
		else $error("error pulse disagrees with status");
	a_valid_pulse: assert property (rx_valid_out && clk_en_in |=> !rx_valid_out)
		else $error("receive pulse longer than one cycle");
	a_char_hold: assert property (!rx_valid_out |-> $stable(rx_char_out))
		else $error("received character changed without pulse");
	// Main scenarios
	c_tx: cover property (tx_valid_in && tx_ready_out);
	c_rx: cover property (rx_valid_out && !rx_err_out);
	c_err: cover property (rx_err_out);
endmodule : ascp_serial_port_chk

bind ascp_serial_port ascp_serial_port_chk u_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
	.bit_rate_select_param_in(bit_rate_select_param_in), .duplex_select_param_in(duplex_select_param_in),
	.rxd_in(rxd_in), .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out),
	.txd_out(txd_out), .txd_oe_out(txd_oe_out), .rx_valid_out(rx_valid_out), .rx_char_out(rx_char_out),
	.rx_err_out(rx_err_out));

/* File: verif/ascp_host_model.sv */
// Host controller on the shared pair
module ascp_host_model (
	input  wire logic ref_clk_in,
	input  wire logic line_in,
	output logic      rxd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rxd_out = 1'b1; // Idle mark level
	// Send one frame, optionally spoilt
	task automatic send(input logic [6:0] d, input logic par_bad, input logic stop_bad, input int bclk);
		logic [9:0] f;
		f = {~stop_bad, (^d) ^ par_bad, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_out <= f[i];
			repeat (bclk) @(posedge ref_clk_in);
		end
		rxd_out <= 1'b1;
	endtask : send
	// Catch one frame at bit centres
	task automatic recv(input int bclk, output logic [9:0] f);
		int n;
		n = 0;
		while (line_in !== 1'b0 && n < 5000) begin
			@(posedge ref_clk_in);
			n++;
		end
		repeat (bclk / 2) @(posedge ref_clk_in);
		for (int i = 0; i < 10; i++) begin
			f[i] = line_in;
			repeat (bclk) @(posedge ref_clk_in);
		end
	endtask : recv
endmodule : ascp_host_model

/* File: verif/ascp_serial_port_tb.sv */
module ascp_serial_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ascp_pkg::*;
	logic clk, rst_n, en, tx_valid, tx_ready, txd, oe, rx_valid, rx_err, rxd, got, er;
	logic [6:0] tx_data;
	ascp_rate_type rate;
	ascp_duplex_type dup;
	ascp_rx_char_type rx_char, ch;
	wire line = oe ? txd : 1'b1; // Host receiver pull-up
	int bad_count = 0;
	int samples_checked = 0;
	ascp_serial_port dut (.ref_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(en), .bit_rate_select_param_in(rate),
		.duplex_select_param_in(dup), .rxd_in(rxd), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
		.tx_ready_out(tx_ready), .txd_out(txd), .txd_oe_out(oe), .rx_valid_out(rx_valid),
		.rx_char_out(rx_char), .rx_err_out(rx_err));
	ascp_host_model host (.ref_clk_in(clk), .line_in(line), .rxd_out(rxd));
	// Compare and count
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic finish_test;
		$display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	// Offer one character, drop request once taken
	task automatic send_char(input logic [6:0] d);
		int n;
		n = 0;
		tx_valid <= 1'b1;
		tx_data <= d;
		do begin
			@(posedge clk);
			n++;
		end while (tx_ready !== 1'b1 && n < 10);
		tx_valid <= 1'b0;
	endtask : send_char
	// Send and decode on the line
	task automatic tx_check(input logic [6:0] d, input int bclk);
		logic [9:0] f;
		fork
			send_char(d);
			host.recv(bclk, f);
		join
		check("tx frame", f, {1'b1, ^d, d, 1'b0});
		check("released", {oe, line}, 2'h1);
	endtask : tx_check
	// Watch for a received character
	task automatic rx_wait(input int n);
		got = 1'b0;
		for (int i = 0; i < n && got !== 1'b1; i++) begin
			@(posedge clk);
			if (rx_valid === 1'b1) begin
				got = 1'b1;
				ch = rx_char;
				er = rx_err;
			end
		end
	endtask : rx_wait
	task automatic t_reset;
		check("reset idle", {tx_ready, oe, txd, rx_valid}, 4'hA);
	endtask : t_reset
	task automatic t_tx_default;
		tx_check(7'h41, 2592);
	endtask : t_tx_default
	task automatic t_full_duplex;
		rate <= ASCP_RATE_38400;
		repeat (4) @(posedge clk);
		fork
			tx_check(7'h2A, 640);
			host.send(7'h55, 1'b0, 1'b0, 640);
			rx_wait(7000);
		join
		check("full rx", {got, er, ch}, {2'h2, 7'h55, 2'h0});
	endtask : t_full_duplex
	task automatic t_half_duplex;
		dup <= ASCP_HALF_DUPLEX;
		repeat (4) @(posedge clk);
		fork
			tx_check(7'h7F, 640);
			host.send(7'h33, 1'b0, 1'b0, 640);
			rx_wait(7000);
		join
		check("half echo ignored", got, 1'b0);
		dup <= ASCP_FULL_DUPLEX;
	endtask : t_half_duplex
	task automatic t_rx_errors;
		rate <= ASCP_RATE_19200;
		repeat (4) @(posedge clk);
		fork
			host.send(7'h1C, 1'b1, 1'b0, 1296);
			rx_wait(14000);
		join
		check("parity err", {got, er, ch}, {2'h3, 7'h1C, 2'h2});
		rate <= ASCP_RATE_38400;
		repeat (4) @(posedge clk);
		fork
			host.send(7'h60, 1'b0, 1'b1, 640);
			rx_wait(7000);
		join
		check("stop err", {got, er, ch}, {2'h3, 7'h60, 2'h1});
	endtask : t_rx_errors
	// Freeze inside the start bit, then reset in mid-frame
	task automatic t_freeze_reset;
		send_char(7'h0F);
		en <= 1'b0;
		repeat (700) @(posedge clk);
		check("frozen start", {oe, txd, tx_ready}, 3'h4);
		en <= 1'b1;
		rst_n <= 1'b0;
		@(posedge clk);
		check("reset floats", {tx_ready, oe, txd, rx_valid}, 4'h2);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check("ready held", tx_ready, 1'b0);
		repeat (2) @(posedge clk);
		check("ready again", {tx_ready, oe, txd}, 3'h5);
	endtask : t_freeze_reset
	// Clock source
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		finish_test;
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		tx_valid = 1'b0;
		en = 1'b1;
		tx_data = 7'h00;
		rate = RATE_DEFAULT;
		dup = ASCP_FULL_DUPLEX;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_reset;
		t_tx_default;
		t_full_duplex;
		t_half_duplex;
		t_rx_errors;
		t_freeze_reset;
		finish_test;
	end
endmodule : ascp_serial_port_tb
